// ### pea_energy_acc.sv
`include "pea_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module pea_energy_acc #(
	parameter int ADDR_W        = 12,
	parameter int SAMPLE_CYCLES = `PEA_SAMPLE_CYCLES
) (
	// Clock and reset.
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave.
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic [31:0]        pwdata,
	output var  logic [31:0]        prdata,
	output var  logic               pready,
	output var  logic               pslverr,
	// Filtered power from the multiplier datapath.
	input  wire pea_pkg::pea_power_s power_in,
	// Interrupt lines: sign change, no load, half full, overflow.
	output var  logic [3:0]         event_interrupt
);

	// The divider retires one quotient bit per clock, one step per magnitude bit.
	// A full sample pass therefore needs about thirty clocks.
	// The sample period must leave room for that pass before the next tick.
	localparam int DIV_STEPS = 26;
	localparam int CNT_W     = $clog2(SAMPLE_CYCLES);

	// Refuse settings the sequence cannot serve.
	generate
		if (SAMPLE_CYCLES < 2 * DIV_STEPS || ADDR_W < 6) begin : g_bad
			$error("pea_energy_acc: SAMPLE_CYCLES too small or ADDR_W too narrow");
		end
	endgenerate

	// Software-visible state.
	logic signed [11:0]  gain1_r;
	logic signed [11:0]  gain2_r;
	logic signed [15:0]  offset1_r;
	logic signed [15:0]  offset2_r;
	logic [7:0]          div_r;
	pea_pkg::pea_ctrl_s  ctrl_r;
	logic [3:0]          flag_r;
	logic [3:0]          mask_r;
	logic [41:0]         acc_r;

	// Bus handshake and interrupt line state.
	logic                pready_r;
	logic [31:0]         prdata_r;
	logic                pslverr_r;
	logic [3:0]          irq_r;

	// Sequencer and divider state.
	pea_pkg::pea_state_e state_r;
	logic [CNT_W-1:0]    tick_cnt_r;
	logic [4:0]          step_r;
	logic [25:0]         quo_r;
	logic [8:0]          rem_r;
	logic                neg_r;
	logic                add_r;
	logic                prev_neg_r;

	// Combinational helpers.
	logic                access;
	logic                latch;
	logic                done;
	logic                hit;
	logic                wr_en;
	logic                rdclr;
	logic [31:0]         rd_data;
	logic                tick;
	pea_pkg::pea_pwr_t   cal1;
	pea_pkg::pea_pwr_t   cal2;
	pea_pkg::pea_pwr_t   pwr;
	logic [26:0]         pair_sum;
	logic                pwr_neg;
	logic [25:0]         pwr_mag;
	logic [25:0]         nl_th;
	logic                below;
	logic                go;
	logic [7:0]          div_eff;
	logic [8:0]          rem_sh;
	logic                rem_ge;
	logic [41:0]         acc_base;
	logic [41:0]         addend;
	logic [41:0]         acc_sum;
	logic [3:0]          ev_set;

	// Gain and offset applied in 1/4096 LSB units, then truncated back.
	// Working in the finer unit keeps the offset exact to 1/128 LSB.
	// The arithmetic shift rounds toward minus infinity, never toward zero.
	// Thirty-eight bits hold the largest input at the largest gain.
	function automatic pea_pkg::pea_pwr_t calibrate(
		input logic signed [23:0] p,
		input logic signed [11:0] g,
		input logic signed [15:0] o
	);
		logic signed [37:0] t;
		t = (38'(p) <<< 12) + 38'(p) * 38'(g) + (38'(o) <<< 5);
		return t[37:12];
	endfunction

	// Per-channel calibration; three-wire mode averages both channels.
	assign cal1     = calibrate(power_in.ch1, gain1_r, offset1_r);
	assign cal2     = calibrate(power_in.ch2, gain2_r, offset2_r);
	assign pair_sum = 27'(cal1) + 27'(cal2);
	assign pwr      = ctrl_r.three_wire ? pair_sum[26:1] : cal1;
	assign pwr_neg  = pwr[25];
	assign pwr_mag  = pwr_neg ? 26'(-pwr) : 26'(pwr);

	// No-load threshold selection and comparison.
	// The comparison uses the magnitude, so creep in either direction is held off.
	// A threshold of zero can never be undercut, which disables the check.
	always_comb begin
		case (ctrl_r.noload_sel)
			2'b01:   nl_th = `PEA_NL_TH1;
			2'b10:   nl_th = `PEA_NL_TH2;
			2'b11:   nl_th = `PEA_NL_TH3;
			default: nl_th = 26'h0000000;
		endcase
	end
	assign below = (ctrl_r.noload_sel != 2'b00) && (pwr_mag < nl_th);

	// Accumulate unless no load, or negative in positive-only mode with absolute mode off.
	assign go = !below && (ctrl_r.absolute_accum || !ctrl_r.positive_only_accum || !pwr_neg);

	// APB phase decode; one wait state before every answer.
	// The wait state lets read data settle in a register before it is shown.
	// A read-clear acts at the latching edge, so the old value is returned.
	assign access = psel & penable;
	assign latch  = access & ~pready_r;
	assign done   = access & pready_r;
	assign wr_en  = done & pwrite & hit;
	assign rdclr  = latch & ~pwrite & (paddr == ADDR_W'(`PEA_OFS_READCLR));

	// Register read mux and address decode.
	always_comb begin
		hit     = 1'b1;
		rd_data = 32'h00000000;
		case (paddr)
			ADDR_W'(`PEA_OFS_GAIN1):   rd_data = {{20{gain1_r[11]}}, gain1_r};
			ADDR_W'(`PEA_OFS_GAIN2):   rd_data = {{20{gain2_r[11]}}, gain2_r};
			ADDR_W'(`PEA_OFS_OFFSET1): rd_data = {{16{offset1_r[15]}}, offset1_r};
			ADDR_W'(`PEA_OFS_OFFSET2): rd_data = {{16{offset2_r[15]}}, offset2_r};
			ADDR_W'(`PEA_OFS_DIVIDER): rd_data = {24'h000000, div_r};
			ADDR_W'(`PEA_OFS_READOUT): rd_data = {8'h00, acc_r[41:18]};
			ADDR_W'(`PEA_OFS_READCLR): rd_data = {8'h00, acc_r[41:18]};
			ADDR_W'(`PEA_OFS_CONTROL): rd_data = {26'h0000000, ctrl_r};
			ADDR_W'(`PEA_OFS_FLAGS):   rd_data = {28'h0000000, flag_r};
			ADDR_W'(`PEA_OFS_MASK):    rd_data = {28'h0000000, mask_r};
			default:                   hit     = 1'b0;
		endcase
	end

	// Bus answer: ready, data and error are latched in the wait cycle.
	// Read data then holds until the next access, which eases slow masters.
	// Write accesses return zero data, so no stale register leaks out.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= latch;
			if (latch) begin
				prdata_r  <= pwrite ? 32'h00000000 : rd_data;
				pslverr_r <= ~hit;
			end
		end
	end

	// Configuration registers, written at the completing edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain1_r   <= `PEA_GAIN_RST;
			gain2_r   <= `PEA_GAIN_RST;
			offset1_r <= `PEA_OFFSET_RST;
			offset2_r <= `PEA_OFFSET_RST;
			div_r     <= `PEA_DIV_RST;
			ctrl_r    <= `PEA_CTRL_RST;
			mask_r    <= `PEA_MASK_RST;
		end else if (wr_en) begin
			case (paddr)
				ADDR_W'(`PEA_OFS_GAIN1):   gain1_r   <= pwdata[11:0];
				ADDR_W'(`PEA_OFS_GAIN2):   gain2_r   <= pwdata[11:0];
				ADDR_W'(`PEA_OFS_OFFSET1): offset1_r <= pwdata[15:0];
				ADDR_W'(`PEA_OFS_OFFSET2): offset2_r <= pwdata[15:0];
				ADDR_W'(`PEA_OFS_DIVIDER): div_r     <= pwdata[7:0];
				ADDR_W'(`PEA_OFS_CONTROL): ctrl_r    <= pwdata[5:0];
				ADDR_W'(`PEA_OFS_MASK):    mask_r    <= pwdata[3:0];
				default:                   div_r     <= div_r;
			endcase
		end
	end

	// Free-running sample timer, one tick per accumulation period.
	// The timer never pauses for bus traffic, so the energy time base is exact.
	// Software therefore sees samples at a fixed phase after reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= '0;
		end else if (tick) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end
	assign tick = (tick_cnt_r == CNT_W'(SAMPLE_CYCLES - 1));

	// Restoring divider step; a zero divider acts as one.
	// Only the magnitude is divided, so the quotient truncates toward zero.
	// The sign is applied again when the quotient is added, except in absolute mode.
	assign div_eff = (div_r == 8'h00) ? 8'h01 : div_r;
	assign rem_sh  = {rem_r[7:0], quo_r[25]};
	assign rem_ge  = rem_sh >= {1'b0, div_eff};

	// Sample sequence: load, divide, accumulate.
	// Power is captured once in the load state and not looked at again.
	// A change of mode during the divide takes effect on the next sample.
	// The accumulate state lasts one clock and then waits for the next tick.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= pea_pkg::PEA_IDLE;
			step_r  <= 5'h00;
			quo_r   <= 26'h0000000;
			rem_r   <= 9'h000;
			neg_r   <= 1'b0;
			add_r   <= 1'b0;
		end else begin
			case (state_r)
				pea_pkg::PEA_IDLE: begin
					if (tick) begin
						state_r <= pea_pkg::PEA_LOAD;
					end
				end
				pea_pkg::PEA_LOAD: begin
					quo_r   <= pwr_mag;
					rem_r   <= 9'h000;
					step_r  <= 5'h00;
					neg_r   <= pwr_neg && !ctrl_r.absolute_accum && !ctrl_r.positive_only_accum;
					add_r   <= go;
					state_r <= pea_pkg::PEA_DIV;
				end
				pea_pkg::PEA_DIV: begin
					rem_r  <= rem_ge ? (rem_sh - {1'b0, div_eff}) : rem_sh;
					quo_r  <= {quo_r[24:0], rem_ge};
					step_r <= step_r + 5'h01;
					if (step_r == 5'(DIV_STEPS - 1)) begin
						state_r <= pea_pkg::PEA_ACC;
					end
				end
				pea_pkg::PEA_ACC: begin
					state_r <= pea_pkg::PEA_IDLE;
				end
				default: begin
					state_r <= pea_pkg::PEA_IDLE;
				end
			endcase
		end
	end

	// Accumulator; a read-clear empties the upper bits before any add.
	// Clearing first means a sample landing in the same clock is not lost.
	// The lower bits are kept, so no fraction of energy is thrown away.
	// The sum wraps modulo the accumulator width on overflow.
	assign acc_base = rdclr ? {24'h000000, acc_r[17:0]} : acc_r;
	assign addend   = neg_r ? 42'(-{16'h0000, quo_r}) : {16'h0000, quo_r};
	assign acc_sum  = acc_base + addend;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r <= 42'h0;
		end else if (state_r == pea_pkg::PEA_ACC && add_r) begin
			acc_r <= acc_sum;
		end else if (rdclr) begin
			acc_r <= acc_base;
		end
	end

	// Sign history, updated once per sample.
	// Zero counts as positive, so a still line never toggles the sign event.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_neg_r <= 1'b0;
		end else if (state_r == pea_pkg::PEA_LOAD) begin
			prev_neg_r <= pwr_neg;
		end
	end

	// Event detection feeding the sticky flags.
	always_comb begin
		ev_set = 4'h0;
		if (state_r == pea_pkg::PEA_LOAD) begin
			ev_set[`PEA_FLG_SIGN]   = ctrl_r.sign_edge_select ? (prev_neg_r && !pwr_neg)
			                                                  : (!prev_neg_r && pwr_neg);
			ev_set[`PEA_FLG_NOLOAD] = below;
		end
		if (state_r == pea_pkg::PEA_ACC && add_r) begin
			ev_set[`PEA_FLG_HALF] = (acc_sum[41] ^ acc_sum[40]) && !(acc_base[41] ^ acc_base[40]);
			ev_set[`PEA_FLG_OVF]  = (addend[41] == acc_base[41]) && (acc_sum[41] != acc_base[41]);
		end
	end

	// Sticky flags cleared by writing zero; a new event wins over the clear.
	// Letting the event win means software can never miss one by clearing late.
	// Writing one to a bit leaves it as it is, so bits clear independently.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flag
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flag_r[gi] <= 1'b0;
				end else if (ev_set[gi]) begin
					flag_r[gi] <= 1'b1;
				end else if (wr_en && paddr == ADDR_W'(`PEA_OFS_FLAGS) && !pwdata[gi]) begin
					flag_r[gi] <= 1'b0;
				end
			end

			// Interrupt line follows its flag while unmasked.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					irq_r[gi] <= 1'b0;
				end else begin
					irq_r[gi] <= flag_r[gi] & ~mask_r[gi];
				end
			end
		end
	endgenerate

	// Outputs straight from flip-flops.
	assign prdata          = prdata_r;
	assign pready          = pready_r;
	assign pslverr         = pslverr_r;
	assign event_interrupt = irq_r;

endmodule

`default_nettype wire

// ### pea_cfg.svh
`ifndef PEA_CFG_SVH
`define PEA_CFG_SVH

// Register byte offsets on the APB port.
`define PEA_OFS_GAIN1      12'h000
`define PEA_OFS_GAIN2      12'h004
`define PEA_OFS_OFFSET1    12'h008
`define PEA_OFS_OFFSET2    12'h00C
`define PEA_OFS_DIVIDER    12'h010
`define PEA_OFS_READOUT    12'h014
`define PEA_OFS_READCLR    12'h018
`define PEA_OFS_CONTROL    12'h01C
`define PEA_OFS_FLAGS      12'h020
`define PEA_OFS_MASK       12'h024

// Bit positions in the flag, mask and interrupt vectors.
`define PEA_FLG_SIGN       0
`define PEA_FLG_NOLOAD     1
`define PEA_FLG_HALF       2
`define PEA_FLG_OVF        3

// Reset values.
`define PEA_GAIN_RST       12'h000
`define PEA_OFFSET_RST     16'h0000
`define PEA_DIV_RST        8'h01
`define PEA_CTRL_RST       6'h00
`define PEA_MASK_RST       4'hF

// No-load thresholds in filtered power LSBs, full scale being 0x200000.
`define PEA_NL_TH1         26'h000013B
`define PEA_NL_TH2         26'h000009D
`define PEA_NL_TH3         26'h000004E

// Sample period of the accumulator and the bus clock period.
`define PEA_SAMPLE_PERIOD_NS 230400
`define PEA_CLK_PERIOD_NS    20
`define PEA_SAMPLE_CYCLES    (`PEA_SAMPLE_PERIOD_NS / `PEA_CLK_PERIOD_NS)

`endif

// ### pea_pkg.sv
package pea_pkg;

	// One filtered power value per channel from the multiplier datapath.
	typedef logic signed [23:0] pea_in_t;

	typedef struct packed {
		pea_in_t ch1;
		pea_in_t ch2;
	} pea_power_s;

	// Calibrated power, wide enough for 1.5x gain plus offset.
	typedef logic signed [25:0] pea_pwr_t;

	// Control register layout, bit 0 at the bottom.
	typedef struct packed {
		logic       three_wire;
		logic [1:0] noload_sel;
		logic       absolute_accum;
		logic       positive_only_accum;
		logic       sign_edge_select;
	} pea_ctrl_s;

	// Sample processing sequence.
	typedef enum logic [1:0] {
		PEA_IDLE = 2'b00,
		PEA_LOAD = 2'b01,
		PEA_DIV  = 2'b11,
		PEA_ACC  = 2'b10
	} pea_state_e;

endpackage

// ### pea_power_src.sv
`timescale 1ns/100ps
`default_nettype none
// Stands in for the multiplier and low-pass filter ahead of the block.
module pea_power_src (
	// Clock and reset.
	input  wire logic                pclk,
	input  wire logic                presetn,
	// Requested power per channel.
	input  wire pea_pkg::pea_in_t    ch1_set,
	input  wire pea_pkg::pea_in_t    ch2_set,
	// Filtered power toward the block.
	output var  pea_pkg::pea_power_s power_in
);
	// The filter output moves only on a clock edge, like the real datapath.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			power_in <= '0;
		else
			power_in <= '{ch1: ch1_set, ch2: ch2_set};
	end
endmodule
`default_nettype wire

// ### pea_energy_acc_checker.sv
`include "pea_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
// Watches the register port and interrupt lines of the energy block.
module pea_energy_acc_checker #(
	parameter int ADDR_W        = 12,
	parameter int SAMPLE_CYCLES = 64
) (
	// Clock and reset.
	input wire logic                pclk,
	input wire logic                presetn,
	// APB.
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [ADDR_W-1:0]   paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// Power and interrupts.
	input wire pea_pkg::pea_power_s power_in,
	input wire logic [3:0]          event_interrupt
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd_done;
	logic sw_wr;
	// Completed reads, and completed writes to the flag or mask words.
	assign rd_done = pready && !pwrite;
	assign sw_wr = pready && pwrite && (paddr == `PEA_OFS_FLAGS || paddr == `PEA_OFS_MASK);

	a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access");
	a_err_unmapped: assert property (pready && paddr > `PEA_OFS_MASK |-> pslverr)
		else $error("unmapped access without error");
	a_err_mapped: assert property (pready && paddr <= `PEA_OFS_MASK && paddr[1:0] == 2'b00
		|-> !pslverr) else $error("error on mapped access");
	a_rdata_hold: assert property (pready |=> $stable(prdata))
		else $error("read data moved after answer");
	a_energy_width: assert property (rd_done && (paddr == `PEA_OFS_READOUT ||
		paddr == `PEA_OFS_READCLR) |-> prdata[31:24] == 8'h00) else $error("energy too wide");
	a_div_width: assert property (rd_done && paddr == `PEA_OFS_DIVIDER
		|-> prdata[31:8] == 24'h000000) else $error("divider too wide");
	a_gain_sext: assert property (rd_done && paddr == `PEA_OFS_GAIN1
		|-> prdata[31:12] == {20{prdata[11]}}) else $error("gain not sign extended");
	a_irq_masked: assert property (sw_wr && paddr == `PEA_OFS_MASK && pwdata[3:0] == 4'hF
		|=> ##1 event_interrupt == 4'h0) else $error("masked interrupt active");
	a_irq_hold: assert property ($fell(event_interrupt[0]) || $fell(event_interrupt[1])
		|-> $past(sw_wr, 2)) else $error("interrupt fell without software write");

	// Main scenarios reached.
	c_read_clear: cover property (rd_done && paddr == `PEA_OFS_READCLR);
	c_sign_irq: cover property ($rose(event_interrupt[0]));
	c_noload_irq: cover property ($rose(event_interrupt[1]));
	c_neg_power: cover property (power_in.ch1[23]);
endmodule
bind pea_energy_acc pea_energy_acc_checker #(.ADDR_W(ADDR_W), .SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.power_in(power_in), .event_interrupt(event_interrupt));
`default_nettype wire

// ### active_power_energy_accumulator_tb.sv
`include "pea_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %h want %h", $time, a, e); end end
// Self-checking bench; power samples come every SC clocks.
module active_power_energy_accumulator_tb;
	localparam int     SC = 64;
	localparam longint FS = 64'h200000;
	localparam longint U  = 64'h40000;
	logic                pclk = 1'b0;
	logic                presetn = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [11:0]         paddr = 12'h000;
	logic [31:0]         pwdata = 32'h0;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic [3:0]          irq;
	pea_pkg::pea_in_t    ch1 = '0;
	pea_pkg::pea_in_t    ch2 = '0;
	pea_pkg::pea_power_s pw;
	logic signed [41:0]  am = '0;
	logic [31:0]         r;
	int                  fails = 0;
	int                  check_count = 0;
	int                  cyc = 0;
	logic [11:0]         gs [3] = '{12'h7FF, 12'h800, 12'h001};
	logic [5:0]          md [3] = '{6'h02, 6'h04, 6'h06};
	logic [23:0]         th [4] = '{24'h0, 24'h13B, 24'h9D, 24'h4E};

	pea_power_src src_u (.pclk(pclk), .presetn(presetn), .ch1_set(ch1), .ch2_set(ch2), .power_in(pw));
	pea_energy_acc #(.ADDR_W(12), .SAMPLE_CYCLES(SC)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_in(pw), .event_interrupt(irq));

	// Clock, and a cycle count since reset that gives the sample phase.
	always #10 pclk = ~pclk;
	always @(posedge pclk) cyc <= presetn ? cyc + 1 : 0;

	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(r, e)
	endtask
	function automatic longint cal(longint p, longint g, longint o);
		return (p * 4096 + p * g + o * 32) >>> 12;
	endfunction
	// Holds power for n samples away from the sample edges, then checks energy.
	task automatic run(input longint p1, input longint p2, input int n, input longint q);
		while (cyc % SC != 40) @(posedge pclk);
		ch1 <= p1[23:0];
		ch2 <= p2[23:0];
		repeat (n * SC) @(posedge pclk);
		ch1 <= 24'h0;
		ch2 <= 24'h0;
		am = am + n * q;
		rd(`PEA_OFS_READOUT, {8'h00, am[41:18]});
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Scenarios in order, each printing one line when done.
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(`PEA_OFS_DIVIDER, 32'h1);
		rd(`PEA_OFS_CONTROL, 32'h0);
		rd(`PEA_OFS_MASK, 32'hF);
		rd(12'h040, 32'h0);
		`CHK(pslverr, 1'b1)
		$display("reset values done");
		run(U, 0, 3, U);
		rd(`PEA_OFS_READOUT, 32'h3);
		rd(`PEA_OFS_READCLR, 32'h3);
		am[41:18] = '0;
		rd(`PEA_OFS_READOUT, 32'h0);
		run(-U, 0, 2, -U);
		rd(`PEA_OFS_FLAGS, 32'h1);
		wr(`PEA_OFS_MASK, 32'hE);
		repeat (2) @(posedge pclk);
		`CHK(irq, 4'h1)
		wr(`PEA_OFS_FLAGS, 32'hE);
		repeat (2) @(posedge pclk);
		`CHK(irq, 4'h0)
		$display("signed and read-clear done");
		foreach (gs[i]) begin
			wr(`PEA_OFS_GAIN1, {20'h0, gs[i]});
			rd(`PEA_OFS_GAIN1, {{20{gs[i][11]}}, gs[i]});
			run(U, 0, 2, cal(U, $signed(gs[i]), 0));
		end
		wr(`PEA_OFS_GAIN1, 32'h0);
		// Idle zero power plus offset stays under the no-load threshold.
		wr(`PEA_OFS_CONTROL, 32'h18);
		wr(`PEA_OFS_OFFSET1, 32'h80);
		run(U - 1, 0, 2, U);
		wr(`PEA_OFS_OFFSET1, 32'hFF80);
		run(U + 1, 0, 2, U);
		wr(`PEA_OFS_OFFSET1, 32'h0);
		wr(`PEA_OFS_DIVIDER, 32'h3);
		run(3 * U + 2, 0, 2, U);
		wr(`PEA_OFS_DIVIDER, 32'h0);
		run(U, 0, 2, U);
		wr(`PEA_OFS_DIVIDER, 32'h1);
		$display("gain offset divider done");
		foreach (md[i]) begin
			wr(`PEA_OFS_CONTROL, {26'h0, md[i]});
			run(-U, 0, 2, md[i] == 6'h02 ? 64'h0 : U);
		end
		wr(`PEA_OFS_CONTROL, 32'h20);
		wr(`PEA_OFS_GAIN2, 32'h7FF);
		run(FS, FS / 2, 2, (FS + cal(FS / 2, 2047, 0)) >>> 1);
		wr(`PEA_OFS_GAIN2, 32'h0);
		wr(`PEA_OFS_CONTROL, 32'h1);
		wr(`PEA_OFS_FLAGS, 32'h0);
		run(-U, 0, 1, -U);
		rd(`PEA_OFS_FLAGS, 32'h0);
		repeat (SC) @(posedge pclk);
		rd(`PEA_OFS_FLAGS, 32'h1);
		$display("modes and edge select done");
		wr(`PEA_OFS_MASK, 32'hD);
		for (int s = 1; s < 4; s++) begin
			wr(`PEA_OFS_CONTROL, 32'(s << 3));
			ch1 <= th[s];
			repeat (2 * SC) @(posedge pclk);
			wr(`PEA_OFS_FLAGS, 32'h0);
			repeat (2 * SC) @(posedge pclk);
			rd(`PEA_OFS_FLAGS, 32'h0);
			`CHK(irq, 4'h0)
			ch1 <= th[s] - 24'h1;
			repeat (2 * SC) @(posedge pclk);
			rd(`PEA_OFS_FLAGS, 32'h2);
			`CHK(irq, 4'h2)
		end
		wr(`PEA_OFS_MASK, 32'hF);
		repeat (2) @(posedge pclk);
		`CHK(irq, 4'h0)
		$display("no-load done");
		summarize();
	end

	// Cuts a hang short well after the expected run length.
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
